// ### psr_host_model.sv
`default_nettype none
// ==========================================================
// Main processor software seen through the command port
module psr_host_model (
  input wire logic i_clock, // System clock
  input wire logic [31:0] i_rdata, // Read word from the bank
  input wire logic i_rvalid, // Read word valid
  output logic o_write, // Write strobe
  output logic o_read, // Read strobe
  output logic [2:0] o_index, // Process selected
  output logic [31:0] o_wdata // Write word
);
  timeunit 1ns;
  timeprecision 1ps;
  import psr_pkg::*;
  // Idle port at time zero
  initial begin
    o_write = 1'b0;
    o_read = 1'b0;
    o_index = 3'h0;
    o_wdata = 32'h0;
  end
  // One access; read with write gives the atomic update
  task automatic access(input logic wr, input logic rd, input logic [2:0] idx,
      input logic [31:0] wd, output logic [31:0] rword, output logic ok);
    @(negedge i_clock);
    o_write = wr;
    o_read = rd;
    o_index = idx;
    o_wdata = wd;
    @(negedge i_clock);
    ok = (i_rvalid === rd);
    rword = i_rdata;
    o_write = 1'b0;
    o_read = 1'b0;
    o_wdata = ~wd; // Released data does not keep its value
  endtask
  // park wake at never, insert enables, restore wake
  task automatic set_enables(input logic [2:0] idx, input logic nz, input logic z);
    logic [31:0] w;
    logic [31:0] old;
    logic ok;
    access(1'b0, 1'b1, idx, 32'h0, old, ok);
    access(1'b1, 1'b1, idx, {old[31:19], 3'h0, old[15:0]}, w, ok);
    w[PSR_B_EN_NZ] = nz;
    w[PSR_B_EN_Z] = z;
    w[PSR_B_QREADY] = 1'b1;
    access(1'b1, 1'b0, idx, w, old, ok);
  endtask
endmodule
`default_nettype wire

// ### psr_pkg.sv
`default_nettype none
package psr_pkg;

  // ==========================================================
  // Process numbering
  localparam int PSR_NPROC = 6;
  localparam logic [2:0] PSR_P_THREAD = 3'h0;
  localparam logic [2:0] PSR_P_DMA = 3'h1;
  localparam logic [2:0] PSR_P_REPLY = 3'h2;
  localparam logic [2:0] PSR_P_CMD = 3'h3;
  localparam logic [2:0] PSR_P_IN0 = 3'h4;
  localparam logic [2:0] PSR_P_IN1 = 3'h5;

  // ==========================================================
  // Field positions of the status word
  localparam int PSR_B_HELD = 31;
  localparam int PSR_B_TRAPEACH = 28;
  localparam int PSR_B_RUNNABLE = 27;
  localparam int PSR_B_EN_NZ = 26;
  localparam int PSR_B_EN_Z = 25;
  localparam int PSR_B_QREADY = 24;
  localparam int PSR_B_REJECT = 23;
  localparam int PSR_B_ACKED = 22;
  localparam int PSR_B_CRCFAIL = 21;
  localparam int PSR_B_SOPERR = 20;
  localparam int PSR_B_MIDPKT = 19;
  localparam int PSR_WAKE_HI = 18;
  localparam int PSR_WAKE_LO = 16;
  localparam int PSR_ADDR_HI = 15;
  localparam int PSR_ADDR_LO = 6;
  localparam int PSR_CAUSE_HI = 5;
  localparam int PSR_CAUSE_LO = 0;

  // ==========================================================
  // Wake condition codes
  typedef enum logic [2:0] {
    PSR_WAKE_NEVER = 3'h0,
    PSR_WAKE_ALWAYS = 3'h1,
    PSR_WAKE_QITEM = 3'h2,
    PSR_WAKE_OUTREADY = 3'h3,
    PSR_WAKE_ACKWAIT = 3'h4,
    PSR_WAKE_SPACE = 3'h5
  } psr_wake_t;

  // ==========================================================
  // Restart microaddresses
  localparam logic [9:0] PSR_IDLE_RESTART_POINT = 10'h001;
  localparam logic [9:0] PSR_INPUT_RESET_ENTRY = 10'h008;
  localparam logic [9:0] PSR_DMA_RESET = 10'h010;
  localparam logic [9:0] PSR_THREAD_RESET = 10'h020;
  localparam logic [9:0] PSR_CMD_RESET = 10'h028;
  localparam logic [9:0] PSR_REPLY_RESET = 10'h030;
  localparam logic [9:0] PSR_INPUT_WAIT_POINT = 10'h163;

  // ==========================================================
  // Reset words: zero-context enable, restart address, inputs awake
  localparam logic [31:0] PSR_RST_THREAD = 32'h0200_0800;
  localparam logic [31:0] PSR_RST_DMA = 32'h0200_0400;
  localparam logic [31:0] PSR_RST_REPLY = 32'h0200_0C00;
  localparam logic [31:0] PSR_RST_CMD = 32'h0200_0A00;
  localparam logic [31:0] PSR_RST_INPUT = 32'h0201_0200;

endpackage
`default_nettype wire

// ### psr_status_bank.sv
`default_nettype none
// Summary of operation
// R1: Six status registers, one per process, readable and writable via command port.
// R2: On exception, the pre-error status word is copied to that process's exception area.
// R3: Bit 31 read-only output-held flag, settable only for reply, DMA, thread.
// R4: On error, an open output is closed with an end-of-packet error.
// R5: Input processes with bit 28 set trap on every received transaction.
// R6: Queued processes runnable when queue-ready set and any run enable set.
// R7: Empty queue or disabled nonzero-context top item clears queue-ready.
// R8: Command runnable on waiting command or interrupt; input runnable on waiting transaction.
// R9: Bits 26/25 enable contexts; inputs auto-nack transactions of disabled context.
// R10: Software changes enables by atomic update with wake never, then restores.
// R11: Queue-ready set whenever process queued; software sets it with enables.
// R12: Bit 23 reject set on nack before acknowledge marker; later transactions discarded.
// R13: Bit 22 shows acknowledge already sent for current packet.
// R14: Bad checksum sets bit 21, raises exception, sets reject if unacknowledged.
// R15: Bit 20 flags packet ended by link reset or new start of packet.
// R16: Bit 19 set on every transaction except end-of-packet.
// R17: Bits 18:16 hold the wake condition code, values 0 to 5.
// R18: Bits 15:6 restart microaddress, bits 5:0 trap cause.
// R19: Reset leaves zeros except zero-context enable, restart address and the wake-always code of input processes.
// R20: Exception sets restart address to idle point 0x001.
// R21: Reset restart addresses: DMA 0x010, thread 0x020, command 0x028.
// R22: Input reset entry 0x008 resets pointers, wakes on queue item, waits 0x163.
module psr_status_bank (
  input wire logic i_clock, // System clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic i_cmd_write, // Command port write strobe
  input wire logic i_cmd_read, // Command port read strobe
  input wire logic [2:0] i_cmd_index, // Process selected
  input wire logic [31:0] i_cmd_wdata, // Write data
  output logic [31:0] o_cmd_rdata, // Read data
  output logic o_cmd_rvalid, // Read data valid pulse
  input wire logic [5:0] i_queue_put, // Item queued, per process
  input wire logic [5:0] i_queue_check, // Engine examined queue top
  input wire logic i_queue_empty, // Queue found empty
  input wire logic i_top_nonzero, // Top item has nonzero context
  input wire logic [5:0] i_out_open, // Output channel opened
  input wire logic [5:0] i_out_close, // Output channel closed normally
  input wire logic i_cmd_pending, // Command waiting in command regs
  input wire logic i_int_pending, // Internal interrupt pending
  input wire logic i_exc_valid, // Exception taken
  input wire logic [2:0] i_exc_proc, // Process taking the exception
  input wire logic [5:0] i_exc_cause, // Trap cause code
  input wire logic [5:0] i_dispatch, // Process dispatched by engine
  input wire logic [1:0] i_rx_waiting, // Transaction waiting, per input
  input wire logic [1:0] i_rx_trans, // Transaction received
  input wire logic i_rx_ctx_nz, // Its context is nonzero
  input wire logic i_rx_eop, // It is an end of packet
  input wire logic i_rx_checksum_failure, // It failed its checksum
  input wire logic i_rx_acknowledge_request_marker, // It carries the acknowledge marker
  input wire logic [1:0] i_rx_sop_err, // Packet ended by reset or new start
  input wire logic [1:0] i_rx_newpkt, // New packet begins
  input wire logic [1:0] i_rx_nack_sent, // Negative acknowledge sent
  input wire logic [1:0] i_rx_ack_sent, // Acknowledge sent
  output logic [5:0] o_runnable, // Runnable per process
  output logic o_exc_write, // Exception area write pulse
  output logic [2:0] o_exc_proc, // Exception area owner
  output logic [31:0] o_exc_data, // Status word at the error
  output logic o_eop_close, // Close output with end-of-packet error
  output logic [1:0] o_auto_nack, // Negative acknowledge request
  output logic [1:0] o_discard, // Drop this transaction
  output logic [1:0] o_trap_req, // Trap to main processor
  output logic [1:0] o_crc_exc, // Checksum exception
  output logic [1:0] o_ptr_reset // Reset input buffer pointers
);
  import psr_pkg::*;

  // ==========================================================
  // Storage and per-process next values
  logic [5:0][31:0] stat_r;
  logic [5:0][31:0] stat_nxt;
  logic [5:0] run_nxt;
  logic [5:0] close_nxt;
  logic [1:0] acknowledge_request_marker_seen_r;
  logic [1:0] acknowledge_request_marker_seen_nxt;
  logic [1:0] nack_nxt;
  logic [1:0] discard_nxt;
  logic [1:0] trap_nxt;
  logic [1:0] crc_nxt;
  logic [1:0] ptr_nxt;

  // R21 reset word, restart address included, of each process
  function automatic logic [31:0] reset_word(input int p);
    if (p == int'(PSR_P_THREAD)) begin
      return PSR_RST_THREAD;
    end else if (p == int'(PSR_P_DMA)) begin
      return PSR_RST_DMA;
    end else if (p == int'(PSR_P_REPLY)) begin
      return PSR_RST_REPLY;
    end else if (p == int'(PSR_P_CMD)) begin
      return PSR_RST_CMD;
    end else begin
      return PSR_RST_INPUT;
    end
  endfunction

  // Exception lands on a process only with a legal index
  wire exc_ok = i_exc_valid && (i_exc_proc < 3'(PSR_NPROC));
  // R2 status word as it stood at the error
  wire [31:0] exc_word = exc_ok ? stat_r[i_exc_proc] : 32'h0000_0000;

  // ==========================================================
  // Per-process field logic
  genvar g;
  generate
    for (g = 0; g < PSR_NPROC; g++) begin : g_proc
      wire [31:0] cur = stat_r[g];
      wire wr_hit = i_cmd_write && (i_cmd_index == 3'(g));
      wire exc_hit = exc_ok && (i_exc_proc == 3'(g));
      wire [31:0] base = wr_hit ? i_cmd_wdata : cur;
      wire en_nz = cur[PSR_B_EN_NZ];
      wire en_z = cur[PSR_B_EN_Z];
      wire is_queued = (g <= int'(PSR_P_REPLY));
      wire is_input = (g >= int'(PSR_P_IN0));
      wire held;
      wire qready;
      wire [9:0] addr;
      wire [2:0] wake;
      wire [5:0] cause;
      wire [4:0] rxflags;
      // Input restart entry; other processes keep their address
      // R22 reset entry moves to the wait point when dispatched
      wire entry_run = is_input && i_dispatch[g] &&
        (cur[PSR_ADDR_HI:PSR_ADDR_LO] == PSR_INPUT_RESET_ENTRY);

      // R3 held flag only for queued output processes
      // R4 exception drops the held flag
      assign held = is_queued && !exc_hit &&
        (i_out_open[g] || (cur[PSR_B_HELD] && !i_out_close[g]));
      // R4 close request when the failing process held output
      assign close_nxt[g] = exc_hit && cur[PSR_B_HELD];

      // R7 queue top not runnable clears queue-ready
      wire qclear = is_queued && i_queue_check[g] && cur[PSR_B_RUNNABLE] &&
        (i_queue_empty || (i_top_nonzero && !en_nz && en_z));
      // R11 queueing sets ready, winning over clear and write
      assign qready = i_queue_put[g] || (!qclear && base[PSR_B_QREADY]);

      // R6 queued runnability
      // R8 command and input runnability
      if (g <= int'(PSR_P_REPLY)) begin : g_rq
        assign run_nxt[g] = cur[PSR_B_QREADY] && (en_nz || en_z);
      end else if (g == int'(PSR_P_CMD)) begin : g_rc
        assign run_nxt[g] = i_cmd_pending || i_int_pending;
      end else begin : g_ri
        assign run_nxt[g] = i_rx_waiting[g-4];
      end

      // R20 exception parks the process at the idle point
      // R18 address and cause fields
      assign addr = exc_hit ? PSR_IDLE_RESTART_POINT :
        entry_run ? PSR_INPUT_WAIT_POINT : base[PSR_ADDR_HI:PSR_ADDR_LO];
      assign cause = exc_hit ? i_exc_cause : base[PSR_CAUSE_HI:PSR_CAUSE_LO];
      // R17 wake condition code
      assign wake = entry_run ? PSR_WAKE_QITEM : base[PSR_WAKE_HI:PSR_WAKE_LO];

      if (g >= int'(PSR_P_IN0)) begin : g_in
        localparam int J = g - 4;
        wire trans = i_rx_trans[J];
        wire np = i_rx_newpkt[J];
        wire rej = cur[PSR_B_REJECT];
        wire acked = cur[PSR_B_ACKED] || i_rx_ack_sent[J];
        wire checksum_failure = trans && i_rx_checksum_failure;
        // R9 disabled context type is negatively acknowledged
        wire ctx_off = i_rx_ctx_nz ? !en_nz : !en_z;
        // R12 nack before the marker, or R14 bad checksum unacknowledged
        wire set_rej = (i_rx_nack_sent[J] && !acknowledge_request_marker_seen_r[J]) ||
          (checksum_failure && !cur[PSR_B_ACKED]);
        assign acknowledge_request_marker_seen_nxt[J] = (trans && i_rx_acknowledge_request_marker) || (!np && acknowledge_request_marker_seen_r[J]);
        // R12 reject and R13 acknowledge, new packet clears, set wins
        assign rxflags[4] = set_rej || (!np && rej);
        assign rxflags[3] = i_rx_ack_sent[J] || (!np && acked);
        // R14 checksum failure flag
        assign rxflags[2] = checksum_failure || (!np && cur[PSR_B_CRCFAIL]);
        // R15 packet cut short
        assign rxflags[1] = i_rx_sop_err[J] || (!np && cur[PSR_B_SOPERR]);
        // R16 mid-packet follows every transaction
        assign rxflags[0] = trans ? !i_rx_eop : cur[PSR_B_MIDPKT];
        assign nack_nxt[J] = trans && !rej && ctx_off;
        assign discard_nxt[J] = trans && rej;
        // R5 single-step trap per transaction
        assign trap_nxt[J] = trans && cur[PSR_B_TRAPEACH];
        // R14 checksum failure raises exception
        assign crc_nxt[J] = checksum_failure;
        // R22 pointer reset on leaving the reset entry
        assign ptr_nxt[J] = entry_run;
      end else begin : g_q
        assign rxflags = 5'h00;
      end

      // R1 assembled status word
      assign stat_nxt[g] = {held, 2'b00, base[PSR_B_TRAPEACH], cur[PSR_B_RUNNABLE],
        base[PSR_B_EN_NZ], base[PSR_B_EN_Z], qready, rxflags, wake, addr, cause};
    end
  endgenerate

  // ==========================================================
  // Command port read path
  wire rd_ok = i_cmd_read && (i_cmd_index < 3'(PSR_NPROC));
  wire [31:0] rd_word = rd_ok ? stat_r[i_cmd_index] : 32'h0000_0000;

  // Status words, runnable bit refreshed each cycle
  // R19 reset words per process
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int p = 0; p < PSR_NPROC; p++) begin
        stat_r[p] <= reset_word(p);
      end
    end else begin
      for (int p = 0; p < PSR_NPROC; p++) begin
        stat_r[p] <= stat_nxt[p] & ~(32'h1 << PSR_B_RUNNABLE) |
          ({31'h0000_0000, run_nxt[p]} << PSR_B_RUNNABLE);
      end
    end
  end

  // Registered outputs and input-side packet state
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cmd_rdata <= 32'h0000_0000;
      o_cmd_rvalid <= 1'b0;
      o_runnable <= 6'h00;
      o_exc_write <= 1'b0;
      o_exc_proc <= 3'h0;
      o_exc_data <= 32'h0000_0000;
      o_eop_close <= 1'b0;
      o_auto_nack <= 2'h0;
      o_discard <= 2'h0;
      o_trap_req <= 2'h0;
      o_crc_exc <= 2'h0;
      o_ptr_reset <= 2'h0;
      acknowledge_request_marker_seen_r <= 2'h0;
    end else begin
      o_cmd_rdata <= rd_word;
      o_cmd_rvalid <= i_cmd_read;
      o_runnable <= run_nxt;
      o_exc_write <= exc_ok;
      o_exc_proc <= i_exc_proc;
      o_exc_data <= exc_word;
      o_eop_close <= |close_nxt;
      o_auto_nack <= nack_nxt;
      o_discard <= discard_nxt;
      o_trap_req <= trap_nxt;
      o_crc_exc <= crc_nxt;
      o_ptr_reset <= ptr_nxt;
      acknowledge_request_marker_seen_r <= acknowledge_request_marker_seen_nxt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  sequence exc_on_held;
    exc_ok && exc_word[PSR_B_HELD];
  endsequence

  sequence entry_dispatch;
    i_dispatch[5] && !exc_ok && stat_r[5][PSR_ADDR_HI:PSR_ADDR_LO] == PSR_INPUT_RESET_ENTRY;
  endsequence

  // R2 exception snapshot copied out
  exc_snapshot_a: assert property (exc_ok |=> o_exc_write && o_exc_data == $past(exc_word)) // R2
    else $error("exception snapshot wrong");
  // R3 command and input never hold output
  held_owner_a: assert property (!stat_r[3][31] && !stat_r[4][31] && !stat_r[5][31]) // R3
    else $error("held flag on wrong process");
  // R4 held output closes on exception
  eop_close_a: assert property (exc_on_held |=> o_eop_close && // R4
    !stat_r[$past(i_exc_proc)][PSR_B_HELD])
    else $error("output not closed on error");
  // R5 single-step trap
  trap_step_a: assert property (i_rx_trans[0] && stat_r[4][PSR_B_TRAPEACH] |=> o_trap_req[0]) // R5
    else $error("no trap on transaction");
  // R6 queued runnability bit
  run_queued_a: assert property ( // R6
    ##1 stat_r[1][PSR_B_RUNNABLE] == $past(stat_r[1][24] && (stat_r[1][26] || stat_r[1][25])))
    else $error("runnable bit wrong");
  // R11 queueing sets ready
  queue_set_a: assert property (i_queue_put[2] |=> stat_r[2][PSR_B_QREADY]) // R11
    else $error("queue-ready not set");
  // R20 idle point after exception
  idle_addr_a: assert property (exc_ok |=> stat_r[$past(i_exc_proc)][15:6] == 10'h001) // R20
    else $error("restart address not idle");
  // R16 end of packet clears mid-packet
  eop_mid_a: assert property (i_rx_trans[1] && i_rx_eop |=> !stat_r[5][PSR_B_MIDPKT]) // R16
    else $error("mid-packet after end");
  // R12 rejected transactions dropped
  reject_drop_a: assert property (i_rx_trans[0] && stat_r[4][23] |=> o_discard[0]) // R12
    else $error("rejected transaction kept");
  // R8 command runnability
  cmd_run_a: assert property (i_cmd_pending |=> o_runnable[3] && stat_r[3][27]) // R8
    else $error("command not runnable");
  // R8 waiting transaction makes input runnable
  in_run_a: assert property (i_rx_waiting[1] |=> // R8
    o_runnable[5] && stat_r[5][PSR_B_RUNNABLE])
    else $error("input not runnable");
  // R1 read answers next cycle
  read_answer_a: assert property (rd_ok |=> o_cmd_rvalid && // R1
    o_cmd_rdata == $past(stat_r[i_cmd_index]))
    else $error("read answer wrong");
  // R1 written enable lands
  write_land_a: assert property (i_cmd_write && i_cmd_index == PSR_P_REPLY |=> // R1
    stat_r[2][PSR_B_EN_Z] == $past(i_cmd_wdata[PSR_B_EN_Z]))
    else $error("write did not land");
  // R3 writes cannot raise the held flag
  held_ro_a: assert property (i_cmd_write && !i_out_open[2] && !stat_r[2][PSR_B_HELD] |=> // R3
    !stat_r[2][PSR_B_HELD])
    else $error("held flag written");
  // R18 trap cause stored
  cause_store_a: assert property (exc_ok |=> // R18
    stat_r[$past(i_exc_proc)][PSR_CAUSE_HI:PSR_CAUSE_LO] == $past(i_exc_cause))
    else $error("trap cause not stored");
  // R7 unrunnable queue top clears queue-ready
  qclear_a: assert property (i_queue_check[0] && stat_r[0][PSR_B_RUNNABLE] && // R7
    !i_queue_put[0] && (i_queue_empty || (i_top_nonzero && !stat_r[0][PSR_B_EN_NZ] &&
    stat_r[0][PSR_B_EN_Z])) |=> !stat_r[0][PSR_B_QREADY])
    else $error("queue-ready not cleared");
  // R9 disabled nonzero context refused
  nack_ctx_a: assert property (i_rx_trans[0] && i_rx_ctx_nz && !stat_r[4][PSR_B_EN_NZ] && // R9
    !stat_r[4][PSR_B_REJECT] |=> o_auto_nack[0])
    else $error("disabled context not refused");
  // R12 early nack sets reject
  reject_set_a: assert property (i_rx_nack_sent[0] && !acknowledge_request_marker_seen_r[0] |=> // R12
    stat_r[4][PSR_B_REJECT])
    else $error("reject not set");
  // R13 acknowledge flag
  ack_flag_a: assert property (i_rx_ack_sent[0] |=> stat_r[4][PSR_B_ACKED]) // R13
    else $error("acknowledge flag not set");
  // R14 checksum flag and exception
  crc_flag_a: assert property (i_rx_trans[0] && i_rx_checksum_failure |=> // R14
    o_crc_exc[0] && stat_r[4][PSR_B_CRCFAIL])
    else $error("checksum failure missed");
  // R14 unacknowledged checksum failure rejects
  crc_reject_a: assert property (i_rx_trans[0] && i_rx_checksum_failure && // R14
    !stat_r[4][PSR_B_ACKED] |=> stat_r[4][PSR_B_REJECT])
    else $error("checksum failure not rejected");
  // R16 transaction inside a packet
  mid_set_a: assert property (i_rx_trans[0] && !i_rx_eop |=> stat_r[4][PSR_B_MIDPKT]) // R16
    else $error("mid-packet not set");
  // R22 reset entry moves to wait point
  entry_wait_a: assert property (entry_dispatch |=> o_ptr_reset[1] && // R22
    stat_r[5][PSR_ADDR_HI:PSR_ADDR_LO] == PSR_INPUT_WAIT_POINT &&
    stat_r[5][PSR_WAKE_HI:PSR_WAKE_LO] == PSR_WAKE_QITEM)
    else $error("reset entry not left");
endmodule
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import psr_pkg::*;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic cw, cr, rv, exw, eopc, exv = 1'b0, qe = 1'b0, tnz = 1'b0, cpend = 1'b0, ipend = 1'b0;
  logic nz = 1'b0, eop = 1'b0, crc = 1'b0, ackm = 1'b0;
  logic [2:0] ci, exo, exp_p = 3'h0;
  logic [31:0] cd, rdat, exd;
  logic [5:0] exc = 6'h0, qput = 6'h0, qchk = 6'h0, oopen = 6'h0, disp = 6'h0, run;
  logic [1:0] rxw = 2'h0, rxt = 2'h0, sope = 2'h0, newp = 2'h0, nacks = 2'h0, acks = 2'h0;
  logic [1:0] anack, disc, trap, crcx, ptr;
  int errors = 0;
  int comparisons = 0;
  // Clock and bounded run
  always #5 i_clock = ~i_clock;
  initial begin
    repeat (20000) @(posedge i_clock);
    errors++;
    $display("unexpected at %0t: run limit reached", $time);
    stop_test();
  end
  psr_host_model host (.i_clock(i_clock), .i_rdata(rdat), .i_rvalid(rv), .o_write(cw),
    .o_read(cr), .o_index(ci), .o_wdata(cd));
  psr_status_bank DUT (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_cmd_write(cw),
    .i_cmd_read(cr), .i_cmd_index(ci), .i_cmd_wdata(cd), .o_cmd_rdata(rdat),
    .o_cmd_rvalid(rv), .i_queue_put(qput), .i_queue_check(qchk), .i_queue_empty(qe),
    .i_top_nonzero(tnz), .i_out_open(oopen), .i_out_close(6'h0), .i_cmd_pending(cpend),
    .i_int_pending(ipend), .i_exc_valid(exv), .i_exc_proc(exp_p), .i_exc_cause(exc),
    .i_dispatch(disp), .i_rx_waiting(rxw), .i_rx_trans(rxt), .i_rx_ctx_nz(nz),
    .i_rx_eop(eop), .i_rx_checksum_failure(crc), .i_rx_acknowledge_request_marker(ackm), .i_rx_sop_err(sope),
    .i_rx_newpkt(newp), .i_rx_nack_sent(nacks), .i_rx_ack_sent(acks), .o_runnable(run),
    .o_exc_write(exw), .o_exc_proc(exo), .o_exc_data(exd), .o_eop_close(eopc),
    .o_auto_nack(anack), .o_discard(disc), .o_trap_req(trap), .o_crc_exc(crcx),
    .o_ptr_reset(ptr));
  // ==========================================================
  // Compare, access and stimulus helpers
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic rd(input logic [2:0] i, input logic [31:0] exp, input string what);
    logic [31:0] w;
    logic ok;
    host.access(1'b0, 1'b1, i, 32'h0, w, ok);
    chk_bit(ok, 1'b1, "read valid");
    chk_word(w, exp, what);
  endtask
  task automatic wr(input logic [2:0] i, input logic [31:0] d);
    logic [31:0] w;
    logic ok;
    host.access(1'b1, 1'b0, i, d, w, ok);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic pulse6(ref logic [5:0] s, input int b);
    @(negedge i_clock);
    s[b] = 1'b1;
    @(negedge i_clock);
    s[b] = 1'b0;
  endtask
  task automatic pulse2(ref logic [1:0] s);
    @(negedge i_clock);
    s[0] = 1'b1;
    @(negedge i_clock);
    s[0] = 1'b0;
  endtask
  // Input transaction on input 0; returns trap, nack, discard, checksum
  task automatic rx_evt(input logic n, input logic e, input logic c, output logic [3:0] got);
    @(negedge i_clock);
    rxt[0] = 1'b1;
    nz = n;
    eop = e;
    crc = c;
    @(negedge i_clock);
    got = {trap[0], anack[0], disc[0], crcx[0]};
    rxt[0] = 1'b0;
    nz = ~n;
    eop = ~e;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(PSR_P_THREAD, 32'h0200_0800, "thread reset");
    rd(PSR_P_DMA, 32'h0200_0400, "dma reset");
    rd(PSR_P_REPLY, 32'h0200_0C00, "reply reset");
    rd(PSR_P_CMD, 32'h0200_0A00, "cmd reset");
    rd(PSR_P_IN0, 32'h0201_0200, "in0 reset");
    rd(PSR_P_IN1, 32'h0201_0200, "in1 reset");
    wr(3'h6, 32'hFFFF_FFFF);
    rd(3'h6, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_queue();
    host.set_enables(PSR_P_THREAD, 1'b0, 1'b1);
    tick(2);
    chk_bit(run[0], 1'b1, "runnable");
    rd(PSR_P_THREAD, 32'h0B00_0800, "enabled");
    tnz = 1'b1;
    pulse6(qchk, 0);
    tnz = 1'b0;
    tick(2);
    chk_bit(run[0], 1'b0, "idle");
    rd(PSR_P_THREAD, 32'h0200_0800, "recheck cleared");
    pulse6(qput, 0);
    tick(2);
    rd(PSR_P_THREAD, 32'h0B00_0800, "requeued");
    qe = 1'b1;
    pulse6(qchk, 0);
    qe = 1'b0;
    tick(2);
    chk_bit(run[0], 1'b0, "queue empty");
    $display("test queue done");
  endtask
  task automatic t_write();
    logic [31:0] w;
    logic ok;
    wr(PSR_P_REPLY, 32'hFFFB_FFFF);
    tick(2);
    rd(PSR_P_REPLY, 32'h1F03_FFFF, "field write");
    host.access(1'b1, 1'b1, PSR_P_REPLY, 32'h0, w, ok);
    chk_word(w, 32'h1F03_FFFF, "atomic old");
    tick(2);
    rd(PSR_P_REPLY, 32'h0, "all cleared");
    $display("test write done");
  endtask
  task automatic t_exc();
    oopen[3] = 1'b1;
    pulse6(oopen, 1);
    oopen[3] = 1'b0;
    exp_p = PSR_P_DMA;
    exc = 6'h2A;
    @(negedge i_clock);
    exv = 1'b1;
    @(negedge i_clock);
    exv = 1'b0;
    chk_bit(exw, 1'b1, "snapshot write");
    chk_word({29'h0, exo}, 32'h1, "snapshot owner");
    chk_word(exd, 32'h8200_0400, "snapshot word");
    chk_bit(eopc, 1'b1, "output closed");
    rd(PSR_P_DMA, 32'h0200_006A, "after exception");
    rd(PSR_P_CMD, 32'h0200_0A00, "cmd never held");
    $display("test exception done");
  endtask
  task automatic t_input();
    logic [3:0] g;
    wr(PSR_P_IN0, 32'h1201_0200);
    rx_evt(1'b1, 1'b0, 1'b0, g);
    chk_word({28'h0, g}, 32'hC, "trap and nack");
    rd(PSR_P_IN0, 32'h1209_0200, "mid packet");
    pulse2(nacks);
    rx_evt(1'b0, 1'b0, 1'b0, g);
    chk_word({28'h0, g}, 32'hA, "discarded");
    pulse2(sope);
    rd(PSR_P_IN0, 32'h1299_0200, "reject and end error");
    pulse2(newp);
    pulse2(acks);
    rx_evt(1'b0, 1'b1, 1'b1, g);
    chk_word({28'h0, g}, 32'h9, "checksum trap");
    rd(PSR_P_IN0, 32'h1261_0200, "acked checksum");
    pulse2(newp);
    rx_evt(1'b0, 1'b1, 1'b1, g);
    rd(PSR_P_IN0, 32'h12A1_0200, "unacked checksum");
    pulse2(newp);
    ackm = 1'b1;
    rx_evt(1'b0, 1'b0, 1'b0, g);
    ackm = 1'b0;
    chk_word({28'h0, g}, 32'h8, "marker trap");
    pulse2(nacks);
    rd(PSR_P_IN0, 32'h1209_0200, "nack after marker");
    $display("test input done");
  endtask
  task automatic t_entry();
    rxw = 2'b10;
    pulse6(disp, 5);
    chk_bit(ptr[1], 1'b1, "pointer reset");
    tick(1);
    chk_bit(run[5], 1'b1, "input waiting");
    rd(PSR_P_IN1, 32'h0A02_58C0, "wait point");
    cpend = 1'b1;
    tick(2);
    chk_bit(run[3], 1'b1, "command waiting");
    cpend = 1'b0;
    ipend = 1'b1;
    tick(2);
    chk_bit(run[3], 1'b1, "interrupt pending");
    ipend = 1'b0;
    tick(2);
    chk_bit(run[3], 1'b0, "command idle");
    $display("test entry done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (16) @(posedge i_clock);
    @(negedge i_clock);
    i_arst_n = 1'b1;
    tick(2);
    t_reset();
    t_queue();
    t_write();
    t_exc();
    t_input();
    t_entry();
    stop_test();
  end
endmodule
`default_nettype wire
